// file: verilog/occ_consts.vh
// Constants for the output compare channel: offsets, fields, reset values
`ifndef OCC_CONSTS_VH
`define OCC_CONSTS_VH

// ----------------------------------------------------------------
// APB byte offsets
// ----------------------------------------------------------------
`define OCC_ADDR_CTRL1 12'h000
`define OCC_ADDR_CTRL2 12'h004
`define OCC_ADDR_PRI 12'h008
`define OCC_ADDR_SEC 12'h00c
`define OCC_ADDR_CNT 12'h010
`define OCC_ADDR_PERIOD 12'h014
`define OCC_ADDR_STATUS 12'h018

// ----------------------------------------------------------------
// Control register 1 fields
// ----------------------------------------------------------------
`define OCC_C1_CLKSEL_HI 12
`define OCC_C1_CLKSEL_LO 10
`define OCC_C1_TRIGGER_STATUS_MODE_BIT 3
`define OCC_C1_MODE_HI 2
`define OCC_C1_MODE_LO 0
`define OCC_C1_MASK 16'h1c0f

// ----------------------------------------------------------------
// Control register 2 fields
// ----------------------------------------------------------------
`define OCC_C2_CASCADE 8
`define OCC_C2_TRIGSEL 7
`define OCC_C2_TRIGGER_STATUS 6
`define OCC_C2_TRIS 5
`define OCC_C2_SYNC_HI 4
`define OCC_C2_SYNC_LO 0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define OCC_ST_FLAG 0
`define OCC_ST_PIN 1
`define OCC_ST_DONE 2

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define OCC_RST_CTRL1 16'h0000
`define OCC_RST_SYNC 5'h00
`define OCC_RST_CNT 16'h0000
`define OCC_RST_CMP 16'h0000
`define OCC_RST_PERIOD 16'hffff
`define OCC_SYNC_NONE 5'h00
`define OCC_SYNC_SELF 5'h1f
`define OCC_CLK_SYS 3'h7
`define OCC_CLK_TIMERS 3'h5
`define OCC_CNT_MAX 16'hffff

// ----------------------------------------------------------------
// Mode select codes
// ----------------------------------------------------------------
`define OCC_M_OFF 3'h0
`define OCC_M_SS_HIGH 3'h1
`define OCC_M_SS_LOW 3'h2
`define OCC_M_TOGGLE 3'h3
`define OCC_M_DBL_SS 3'h4
`define OCC_M_DBL_CONT 3'h5
`define OCC_M_PWM_EDGE 3'h6
`define OCC_M_PWM_CTR 3'h7

`endif

// file: verilog/occ_match.v
// Counter-to-compare-value match detector, one per compare value
`timescale 1ns/1ps
`default_nettype none

module occ_match (
	input wire [15:0] count_i,
	input wire [15:0] value_i,
	input wire fresh_i,
	input wire cascade_i,
	input wire partner_match_i,
	output wire match_o
);

	// One event per counter value; in cascade the high half must match too
	assign match_o = fresh_i & (count_i == value_i) & (~cascade_i | partner_match_i);

endmodule

`default_nettype wire

// file: verilog/occ_channel.v
// Output compare channel with dedicated counter, sync/trigger, cascade and PWM
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "occ_consts.vh"

module occ_channel (
	input wire clk_sys_i,
	input wire srst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	input wire [4:0] timer_tick_i,
	input wire [31:0] sync_event_i,
	input wire channel_is_even_i,
	input wire partner_cascade_i,
	input wire partner_carry_i,
	input wire partner_pri_match_i,
	input wire partner_sec_match_i,
	output wire cascade_en_o,
	output wire carry_o,
	output wire pri_level_o,
	output wire sec_level_o,
	output wire pin_o,
	output wire pin_oe_n_o,
	output wire channel_interrupt_flag_o
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [15:0] control_register_1_ff;
	reg cascade_enable_bit_ff;
	reg trigger_select_bit_ff;
	reg trigger_status_ff;
	reg output_tristate_control_ff;
	reg [4:0] sync_source_select_ff;
	reg [15:0] primary_compare_value_ff;
	reg [15:0] secondary_compare_value_ff;
	reg [15:0] timer_period_register_ff;
	reg [15:0] channel_counter_ff;
	reg [15:0] pri_shadow_ff;
	reg [15:0] sec_shadow_ff;
	reg fresh_ff;
	reg pin_ff;
	reg done_ff;
	reg flag_ff;
	reg ack_ff;
	reg [31:0] prdata_ff;

	wire [2:0] mode_select_field;
	wire [2:0] clock_source_select;
	wire trigger_status_mode_bit;
	wire is_pwm;
	wire cascade_on;
	wire tick;
	wire advance;
	wire sync_evt;
	wire trig_mode;
	wire sync_mode;
	wire hold;
	wire period_hit;
	wire [15:0] pri_eff;
	wire [15:0] sec_eff;
	wire pri_match;
	wire sec_match;
	wire wr_c1;
	wire wr_c2;
	wire wr_st;
	wire wr_cnt;
	wire bus_wr;
	wire addr_hit;
	reg [31:0] rd_mux;
	reg [15:0] nxt_cnt;
	reg nxt_pin;
	reg nxt_done;
	reg evt_flag;

	assign mode_select_field = control_register_1_ff[`OCC_C1_MODE_HI:`OCC_C1_MODE_LO];
	assign clock_source_select = control_register_1_ff[`OCC_C1_CLKSEL_HI:`OCC_C1_CLKSEL_LO];
	assign trigger_status_mode_bit = control_register_1_ff[`OCC_C1_TRIGGER_STATUS_MODE_BIT];
	assign is_pwm = mode_select_field[2] & mode_select_field[1];

	// ----------------------------------------------------------------
	// APB slave: one wait state, write and read data at the pready edge
	// ----------------------------------------------------------------
	assign pready_o = ack_ff;
	assign prdata_o = prdata_ff;
	assign bus_wr = psel_i & penable_i & pwrite_i & ack_ff;
	assign addr_hit = (paddr_i == `OCC_ADDR_CTRL1) | (paddr_i == `OCC_ADDR_CTRL2) |
		(paddr_i == `OCC_ADDR_PRI) | (paddr_i == `OCC_ADDR_SEC) |
		(paddr_i == `OCC_ADDR_CNT) | (paddr_i == `OCC_ADDR_PERIOD) |
		(paddr_i == `OCC_ADDR_STATUS);
	assign pslverr_o = ack_ff & ~addr_hit;
	assign wr_c1 = bus_wr & (paddr_i == `OCC_ADDR_CTRL1);
	assign wr_c2 = bus_wr & (paddr_i == `OCC_ADDR_CTRL2);
	assign wr_st = bus_wr & (paddr_i == `OCC_ADDR_STATUS);
	assign wr_cnt = bus_wr & (paddr_i == `OCC_ADDR_CNT);

	// Read multiplexer; unmapped addresses read as zero
	always @* begin
		rd_mux = 32'h00000000;
		case (paddr_i)
			`OCC_ADDR_CTRL1: rd_mux = {16'h0000, control_register_1_ff};
			`OCC_ADDR_CTRL2: rd_mux = {23'h0, cascade_enable_bit_ff, trigger_select_bit_ff,
				trigger_status_ff, output_tristate_control_ff, sync_source_select_ff};
			`OCC_ADDR_PRI: rd_mux = {16'h0000, primary_compare_value_ff};
			`OCC_ADDR_SEC: rd_mux = {16'h0000, secondary_compare_value_ff};
			`OCC_ADDR_CNT: rd_mux = {16'h0000, channel_counter_ff};
			`OCC_ADDR_PERIOD: rd_mux = {16'h0000, timer_period_register_ff};
			`OCC_ADDR_STATUS: rd_mux = {29'h0, done_ff, pin_ff, flag_ff};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Access handshake and read capture
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			ack_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			ack_ff <= psel_i & penable_i & ~ack_ff;
			if (psel_i & penable_i & ~ack_ff & ~pwrite_i)
				prdata_ff <= rd_mux;
		end
	end

	// Software-written configuration
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			control_register_1_ff <= `OCC_RST_CTRL1;
			cascade_enable_bit_ff <= 1'b0;
			trigger_select_bit_ff <= 1'b0;
			output_tristate_control_ff <= 1'b0;
			sync_source_select_ff <= `OCC_RST_SYNC;
			primary_compare_value_ff <= `OCC_RST_CMP;
			secondary_compare_value_ff <= `OCC_RST_CMP;
			timer_period_register_ff <= `OCC_RST_PERIOD;
		end else if (bus_wr) begin
			if (wr_c1)
				control_register_1_ff <= pwdata_i[15:0] & `OCC_C1_MASK;
			if (wr_c2) begin
				cascade_enable_bit_ff <= pwdata_i[`OCC_C2_CASCADE];
				trigger_select_bit_ff <= pwdata_i[`OCC_C2_TRIGSEL];
				output_tristate_control_ff <= pwdata_i[`OCC_C2_TRIS];
				sync_source_select_ff <= pwdata_i[`OCC_C2_SYNC_HI:`OCC_C2_SYNC_LO];
			end
			if (paddr_i == `OCC_ADDR_PRI)
				primary_compare_value_ff <= pwdata_i[15:0];
			if (paddr_i == `OCC_ADDR_SEC)
				secondary_compare_value_ff <= pwdata_i[15:0];
			if (paddr_i == `OCC_ADDR_PERIOD)
				timer_period_register_ff <= pwdata_i[15:0];
		end
	end

	// ----------------------------------------------------------------
	// Time base, sync and trigger
	// ----------------------------------------------------------------
	// Tick from the selected timer, or every cycle for the system clock
	assign tick = (clock_source_select == `OCC_CLK_SYS) ? 1'b1 :
		((clock_source_select < `OCC_CLK_TIMERS) ? timer_tick_i[clock_source_select] : 1'b0);

	assign cascade_on = cascade_enable_bit_ff & partner_cascade_i;
	assign cascade_en_o = cascade_enable_bit_ff;

	// Even half of a cascade counts the odd half's wraps instead of ticks
	assign advance = (cascade_on & channel_is_even_i) ? partner_carry_i : tick;
	assign carry_o = advance & (channel_counter_ff == `OCC_CNT_MAX);

	// Period match: reset point of a self-synced channel
	assign period_hit = advance & (channel_counter_ff == timer_period_register_ff);

	// Sync source: external event by index, or own period match for 1Fh
	assign sync_evt = (sync_source_select_ff == `OCC_SYNC_SELF) ? period_hit :
		sync_event_i[sync_source_select_ff];
	assign trig_mode = (sync_source_select_ff != `OCC_SYNC_NONE) & trigger_select_bit_ff;
	assign sync_mode = (sync_source_select_ff != `OCC_SYNC_NONE) & ~trigger_select_bit_ff;

	// Trigger mode keeps the counter clear until triggered
	assign hold = trig_mode & ~trigger_status_ff;

	// Trigger status: hardware set wins over any clear
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			trigger_status_ff <= 1'b0;
		end else if (trig_mode & sync_evt) begin
			trigger_status_ff <= 1'b1;
		end else if (wr_c2) begin
			trigger_status_ff <= pwdata_i[`OCC_C2_TRIGGER_STATUS];
		end else if (trigger_status_mode_bit & sec_match) begin
			trigger_status_ff <= 1'b0;
		end
	end

	// Counter next value: write, hold, sync reset, then count
	always @* begin
		nxt_cnt = channel_counter_ff;
		if (wr_cnt)
			nxt_cnt = pwdata_i[15:0];
		else if (hold)
			nxt_cnt = `OCC_RST_CNT;
		else if (sync_mode & sync_evt)
			nxt_cnt = `OCC_RST_CNT;
		else if (advance)
			nxt_cnt = channel_counter_ff + 16'h0001;
	end

	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			channel_counter_ff <= `OCC_RST_CNT;
			fresh_ff <= 1'b0;
		end else begin
			channel_counter_ff <= nxt_cnt;
			fresh_ff <= ~hold & (advance | (sync_mode & sync_evt));
		end
	end

	// ----------------------------------------------------------------
	// Compare values and matches
	// ----------------------------------------------------------------
	// PWM shadows reload at the end of each period
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			pri_shadow_ff <= `OCC_RST_CMP;
			sec_shadow_ff <= `OCC_RST_CMP;
		end else if (period_hit | ~is_pwm) begin
			pri_shadow_ff <= primary_compare_value_ff;
			sec_shadow_ff <= secondary_compare_value_ff;
		end
	end

	assign pri_eff = is_pwm ? pri_shadow_ff : primary_compare_value_ff;
	assign sec_eff = is_pwm ? sec_shadow_ff : secondary_compare_value_ff;

	// Match on primary compare value
	occ_match u_pri_match (
		.count_i(channel_counter_ff),
		.value_i(pri_eff),
		.fresh_i(fresh_ff),
		.cascade_i(cascade_on & ~channel_is_even_i),
		.partner_match_i(partner_pri_match_i),
		.match_o(pri_match)
	);

	// Match on secondary compare value
	occ_match u_sec_match (
		.count_i(channel_counter_ff),
		.value_i(sec_eff),
		.fresh_i(fresh_ff),
		.cascade_i(cascade_on & ~channel_is_even_i),
		.partner_match_i(partner_sec_match_i),
		.match_o(sec_match)
	);

	// Level compares shared with the odd partner in a cascade
	assign pri_level_o = (channel_counter_ff == pri_eff);
	assign sec_level_o = (channel_counter_ff == sec_eff);

	// ----------------------------------------------------------------
	// Output waveform
	// ----------------------------------------------------------------
	always @* begin
		nxt_pin = pin_ff;
		nxt_done = done_ff;
		evt_flag = 1'b0;
		case (mode_select_field)
			`OCC_M_OFF: begin
				nxt_pin = 1'b0;
			end
			`OCC_M_SS_HIGH: begin
				if (pri_match & ~done_ff) begin
					nxt_pin = 1'b1;
					nxt_done = 1'b1;
					evt_flag = 1'b1;
				end
			end
			`OCC_M_SS_LOW: begin
				if (pri_match & ~done_ff) begin
					nxt_pin = 1'b0;
					nxt_done = 1'b1;
					evt_flag = 1'b1;
				end
			end
			`OCC_M_TOGGLE: begin
				if (pri_match) begin
					nxt_pin = ~pin_ff;
					evt_flag = 1'b1;
				end
			end
			`OCC_M_DBL_SS: begin
				if (pri_match & ~done_ff)
					nxt_pin = 1'b1;
				if (sec_match & ~done_ff & (pin_ff | pri_match)) begin
					nxt_pin = 1'b0;
					nxt_done = 1'b1;
					evt_flag = 1'b1;
				end
			end
			`OCC_M_DBL_CONT: begin
				if (pri_match)
					nxt_pin = 1'b1;
				if (sec_match) begin
					nxt_pin = 1'b0;
					evt_flag = 1'b1;
				end
			end
			`OCC_M_PWM_EDGE: begin
				// High from period start, low at secondary match
				if (period_hit)
					nxt_pin = (sec_shadow_ff != `OCC_RST_CMP) |
						(secondary_compare_value_ff != `OCC_RST_CMP);
				if (sec_match)
					nxt_pin = 1'b0;
			end
			`OCC_M_PWM_CTR: begin
				// High between primary and secondary matches
				if (pri_match)
					nxt_pin = 1'b1;
				if (sec_match)
					nxt_pin = 1'b0;
			end
			default: begin
				nxt_pin = pin_ff;
			end
		endcase
	end

	// Pin, single-shot done and sticky channel flag
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			pin_ff <= 1'b0;
			done_ff <= 1'b0;
			flag_ff <= 1'b0;
		end else begin
			if (wr_c1) begin
				// Rewriting control 1 rearms and sets the default level
				pin_ff <= (pwdata_i[`OCC_C1_MODE_HI:`OCC_C1_MODE_LO] == `OCC_M_SS_LOW);
				done_ff <= 1'b0;
			end else begin
				pin_ff <= nxt_pin;
				done_ff <= nxt_done;
			end
			if (evt_flag)
				flag_ff <= 1'b1;
			else if (wr_st & pwdata_i[`OCC_ST_FLAG])
				flag_ff <= 1'b0;
		end
	end

	assign pin_o = pin_ff;
	assign pin_oe_n_o = output_tristate_control_ff;
	assign channel_interrupt_flag_o = flag_ff;

endmodule

`default_nettype wire

// file: testbench/occ_channel_asserts.sv
// Port-level concurrent checks for the output compare channel
`timescale 1ns/1ps
`default_nettype none
`include "occ_consts.vh"
module occ_channel_asserts (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic [4:0] timer_tick_i,
	input wire logic [31:0] sync_event_i,
	input wire logic partner_carry_i,
	input wire logic cascade_en_o,
	input wire logic carry_o,
	input wire logic pri_level_o,
	input wire logic sec_level_o,
	input wire logic pin_o,
	input wire logic pin_oe_n_o,
	input wire logic channel_interrupt_flag_o
);
	logic [2:0] mode_ff, clk_ff;
	logic [4:0] sync_ff;
	logic trig_ff, pri0_ff, wr_any, wr_c1, wr_c2, lv, idle, run7, sclr;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	// Completed writes and any compare level
	assign wr_any = psel_i & penable_i & pready_o & pwrite_i;
	assign wr_c1 = wr_any & (paddr_i == `OCC_ADDR_CTRL1);
	assign wr_c2 = wr_any & (paddr_i == `OCC_ADDR_CTRL2);
	assign lv = pri_level_o | sec_level_o;
	// Shadow of the control fields that gate the checks
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			mode_ff <= 3'h0;
			clk_ff <= 3'h0;
			sync_ff <= 5'h00;
			trig_ff <= 1'b0;
			pri0_ff <= 1'b1;
		end else begin
			if (wr_c1) begin
				mode_ff <= pwdata_i[2:0];
				clk_ff <= pwdata_i[12:10];
			end
			if (wr_c2) begin
				sync_ff <= pwdata_i[4:0];
				trig_ff <= pwdata_i[7];
			end
			if (wr_any & (paddr_i == `OCC_ADDR_PRI))
				pri0_ff <= (pwdata_i[15:0] == 16'h0000);
		end
	end
	// Counter frozen, counter stepping every cycle, sync clear due
	assign idle = (clk_ff < 3'h5) & ~timer_tick_i[clk_ff] & (sync_event_i == 32'h0) & ~psel_i
		& ~partner_carry_i & (sync_ff == 5'h00) & (mode_ff < 3'h6);
	assign run7 = (clk_ff == 3'h7) & (sync_ff == 5'h00) & ~psel_i & ~cascade_en_o
		& (mode_ff < 3'h6);
	assign sclr = (clk_ff == 3'h7) & (sync_ff != 5'h00) & (sync_ff != 5'h1f) & ~trig_ff
		& sync_event_i[sync_ff] & pri0_ff & ~psel_i & (mode_ff < 3'h6);

	a_carry_one_pulse: assert property (carry_o |=> !carry_o)
		else $error("carry held longer than one cycle");
	a_match_one_cycle: assert property (run7 && $rose(pri_level_o) |=> !pri_level_o)
		else $error("counter did not step on the system clock");
	a_idle_no_step: assert property (idle |=> $stable(pri_level_o) && $stable(sec_level_o))
		else $error("counter moved without a tick");
	a_sync_clears: assert property (sclr |-> ##[1:2] pri_level_o)
		else $error("sync event did not clear the counter");
	a_flag_cause: assert property ($rose(channel_interrupt_flag_o)
		|-> $past(lv) || $past(lv, 2) || $past(lv, 3))
		else $error("flag set without a compare match");
	a_pin_cause: assert property ($changed(pin_o) && mode_ff < 3'h6
		|-> $past(lv) || $past(lv, 2) || $past(lv, 3) || $past(wr_c1))
		else $error("pin changed without match or control write");
	a_tris_drive: assert property (wr_c2 |=> pin_oe_n_o == $past(pwdata_i[5]))
		else $error("output enable does not follow tristate bit");
	a_cascade_bit: assert property (wr_c2 |=> cascade_en_o == $past(pwdata_i[8]))
		else $error("cascade enable does not follow control write");

	c_wrap: cover property (carry_o);
	c_flag: cover property ($rose(channel_interrupt_flag_o));
	c_sync: cover property (sclr);
endmodule

bind occ_channel occ_channel_asserts chk_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pready_o(pready_o), .timer_tick_i(timer_tick_i),
	.sync_event_i(sync_event_i), .partner_carry_i(partner_carry_i),
	.cascade_en_o(cascade_en_o), .carry_o(carry_o), .pri_level_o(pri_level_o),
	.sec_level_o(sec_level_o), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
	.channel_interrupt_flag_o(channel_interrupt_flag_o));
`default_nettype wire

// file: testbench/occ_partner.sv
// Far side model: timer ticks, sync sources and the odd partner's wraps
`timescale 1ns/1ps
`default_nettype none
module occ_partner (
	input wire logic clk_i,
	input wire logic [4:0] tick_req_i,
	input wire logic [31:0] sync_req_i,
	input wire logic carry_req_i,
	output logic [4:0] timer_tick_o,
	output logic [31:0] sync_event_o,
	output logic carry_o
);
	// Requests are registered and appear one cycle after the edge, as long as they are held; slow rates come from spacing
	always @(posedge clk_i) begin
		timer_tick_o <= tick_req_i;
		sync_event_o <= sync_req_i;
		carry_o <= carry_req_i;
	end
endmodule
`default_nettype wire

// file: testbench/tb_output_compare_sync_cascade_pwm.sv
// Self-checking bench for the output compare channel
`timescale 1ns/1ps
`default_nettype none
`include "occ_consts.vh"
module tb_output_compare_sync_cascade_pwm;
	logic clk_sys_i = 0;
	logic srst_i = 1;
	logic psel = 0, pen = 0, pwr = 0, even = 0, pcas = 0, creq = 0, pm = 0, err;
	logic [11:0] pa = 0;
	logic [31:0] pwd = 0, sreq = 0, rd, prdata, sev;
	logic [4:0] treq = 0, tick;
	logic pready, pslverr, cas_o, carry, pl, sl, pin, oe_n, flag, pcarry;
	logic [15:0] lfsr = 16'h001d, p;
	logic [15:0] tc [9] = '{16'h1c01, 0, 16'h1c02, 16'h1c03, 0, 16'h1c04, 0, 16'h1c05, 0};
	logic [3:0] te [9] = '{4'hf, 4'ha, 4'h5, 4'hf, 4'h5, 4'h9, 4'h0, 4'h9, 4'h9};
	int mismatches = 0, checks_done = 0, cyc = 0, nc = 0, n, hi, per;

	occ_partner far_u (.clk_i(clk_sys_i), .tick_req_i(treq), .sync_req_i(sreq),
		.carry_req_i(creq), .timer_tick_o(tick), .sync_event_o(sev), .carry_o(pcarry));
	occ_channel dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .timer_tick_i(tick), .sync_event_i(sev),
		.channel_is_even_i(even), .partner_cascade_i(pcas), .partner_carry_i(pcarry),
		.partner_pri_match_i(pm), .partner_sec_match_i(pm), .cascade_en_o(cas_o),
		.carry_o(carry), .pri_level_o(pl), .sec_level_o(sl), .pin_o(pin),
		.pin_oe_n_o(oe_n), .channel_interrupt_flag_o(flag));

	// Clock, run limit and count of counter wraps
	always #2.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (carry === 1'b1)
			nc <= nc + 1;
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	function automatic logic [15:0] rnd(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Expected PWM period and center-aligned high time
	function automatic int pwm_per(input int prd);
		return prd + 1;
	endfunction
	function automatic int ctr_hi(input int a, input int b);
		return b - a;
	endfunction

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge clk_sys_i);
	endtask
	// APB transfer: hold until pready is sampled high, then release
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk_sys_i);
		pen <= 1;
		@(posedge clk_sys_i);
		while (pready !== 1'b1) @(posedge clk_sys_i);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		pen <= 0;
		@(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask
	task automatic fire(input logic [31:0] m);
		sreq <= m;
		@(posedge clk_sys_i);
		sreq <= 0;
		@(posedge clk_sys_i);
	endtask
	task automatic carries();
		repeat (3) begin
			creq <= 1;
			@(posedge clk_sys_i);
			creq <= 0;
			@(posedge clk_sys_i);
		end
		wt(3);
	endtask
	task automatic meas();
		hi = 0;
		per = 0;
		while (pin !== 1'b0) @(posedge clk_sys_i);
		while (pin !== 1'b1) @(posedge clk_sys_i);
		while (pin === 1'b1) begin
			hi++;
			@(posedge clk_sys_i);
		end
		per = hi;
		while (pin === 1'b0) begin
			per++;
			@(posedge clk_sys_i);
		end
	endtask
	task automatic hold(input logic v);
		wt(40);
		repeat (20) begin
			chk(pin, v);
			@(posedge clk_sys_i);
		end
	endtask

	initial begin
		wt(12);
		srst_i <= 0;
		@(posedge clk_sys_i);
		// Reset state and an unmapped address
		rdc(`OCC_ADDR_CTRL1, 0);
		rdc(`OCC_ADDR_CTRL2, 0);
		rdc(`OCC_ADDR_PERIOD, 32'hffff);
		apb(0, 12'h01c, 32'h0);
		chk(err, 1);
		chk(oe_n, 0);
		// Free-running wrap on the system clock
		wr(`OCC_ADDR_CTRL1, 32'h1c00);
		wr(`OCC_ADDR_CNT, 32'hfff0);
		wt(30);
		apb(0, `OCC_ADDR_CNT, 0);
		chk(rd < 32'h40, 1);
		chk(nc, 1);
		// Random timer ticks, other timers ticking too
		wr(`OCC_ADDR_CTRL1, 32'h0400);
		wr(`OCC_ADDR_CNT, 0);
		lfsr = rnd(lfsr);
		n = lfsr[3:0] + 3;
		repeat (n) begin
			treq <= 5'h02;
			@(posedge clk_sys_i);
			treq <= 5'h1d;
			wt(lfsr[1:0] + 1);
		end
		treq <= 0;
		wt(4);
		rdc(`OCC_ADDR_CNT, n);
		// Synchronous then trigger operation on source 3
		wr(`OCC_ADDR_CTRL1, 32'h1c00);
		wr(`OCC_ADDR_CTRL2, 32'h03);
		wt(60);
		fire(32'h8);
		apb(0, `OCC_ADDR_CNT, 0);
		chk(rd < 32'h10, 1);
		wr(`OCC_ADDR_CTRL2, 32'h83);
		wt(10);
		rdc(`OCC_ADDR_CNT, 0);
		fire(32'h8);
		wt(20);
		apb(0, `OCC_ADDR_CNT, 0);
		chk(rd > 32'h10, 1);
		rdc(`OCC_ADDR_CTRL2, 32'hc3);
		// Status mode bit set: a secondary match at zero clears the trigger
		wr(`OCC_ADDR_CTRL1, 32'h1c08);
		wr(`OCC_ADDR_CNT, 32'hfff8);
		wt(20);
		rdc(`OCC_ADDR_CTRL2, 32'h83);
		rdc(`OCC_ADDR_CNT, 0);
		// Compare modes: pin and flag midway and after the secondary match
		wr(`OCC_ADDR_CTRL2, 0);
		lfsr = rnd(lfsr);
		p = 16'h0200 + lfsr[7:0];
		wr(`OCC_ADDR_PRI, p);
		wr(`OCC_ADDR_SEC, p + 16'h003c);
		for (int i = 0; i < 9; i++) begin
			wr(`OCC_ADDR_STATUS, 1);
			wr(`OCC_ADDR_CNT, p - 16'd100);
			if (tc[i] != 0)
				wr(`OCC_ADDR_CTRL1, tc[i]);
			else
				wt(4);
			wt(125);
			chk({pin, flag}, te[i][3:2]);
			wt(60);
			chk({pin, flag}, te[i][1:0]);
		end
		// PWM on its own period
		lfsr = rnd(lfsr);
		n = 7 + lfsr[2:0];
		wr(`OCC_ADDR_PERIOD, n);
		wr(`OCC_ADDR_CNT, 0);
		wr(`OCC_ADDR_CTRL2, 32'h1f);
		wr(`OCC_ADDR_PRI, 2);
		wr(`OCC_ADDR_SEC, 5);
		wr(`OCC_ADDR_CTRL1, 32'h1c07);
		meas();
		meas();
		chk(hi, ctr_hi(2, 5));
		chk(per, pwm_per(n));
		wr(`OCC_ADDR_CTRL1, 32'h1c06);
		meas();
		meas();
		chk(per, pwm_per(n));
		wr(`OCC_ADDR_SEC, n + 3);
		hold(1);
		wr(`OCC_ADDR_PRI, 0);
		wr(`OCC_ADDR_SEC, 0);
		wr(`OCC_ADDR_PERIOD, 0);
		hold(0);
		// Cascade: even half counts partner wraps only when both enable
		wr(`OCC_ADDR_CTRL2, 0);
		wr(`OCC_ADDR_CTRL1, 32'h0400);
		even <= 1;
		pcas <= 1;
		wr(`OCC_ADDR_CTRL2, 32'h100);
		chk(cas_o, 1);
		wr(`OCC_ADDR_CNT, 0);
		carries();
		rdc(`OCC_ADDR_CNT, 3);
		wr(`OCC_ADDR_CTRL2, 0);
		carries();
		rdc(`OCC_ADDR_CNT, 3);
		pcas <= 0;
		wr(`OCC_ADDR_CTRL2, 32'h120);
		carries();
		rdc(`OCC_ADDR_CNT, 3);
		chk(oe_n, 1);
		wr(`OCC_ADDR_CTRL2, 0);
		chk(oe_n, 0);
		// Odd half: a primary match needs the partner's level match too
		even <= 0;
		pcas <= 1;
		wr(`OCC_ADDR_CTRL2, 32'h100);
		wr(`OCC_ADDR_PRI, 2);
		wr(`OCC_ADDR_CTRL1, 32'h0401);
		repeat (2) begin
			wr(`OCC_ADDR_CNT, 0);
			repeat (3) begin
				treq <= 5'h02;
				@(posedge clk_sys_i);
				treq <= 5'h00;
				@(posedge clk_sys_i);
			end
			wt(3);
			chk(pin, pm);
			pm <= 1;
		end
		finish_test();
	end
endmodule
`default_nettype wire
